// ---- core/vsup_pkg.sv ----
`default_nettype none
package vsup_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ       = 40_000_000;
	localparam int TICK_MS      = 5;
	localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
	localparam int HIST_MS      = 40;
	localparam int HIST_DEPTH   = HIST_MS / TICK_MS;
	localparam int OP_MAX_S     = 1800;
	localparam int OP_MAX_TICKS = OP_MAX_S * 1000 / TICK_MS;

	// ****************************************
	// widths and sizes
	// ****************************************
	localparam int CH_N     = 4;
	localparam int PH_N     = 3;
	localparam int MAG_W    = 12;
	localparam int ANG_W    = 16;
	localparam int THR_W    = 7;
	localparam int DLY_W    = 19;
	localparam int TIME_W   = 20;
	localparam int RAT_W    = 16;
	localparam int STAMP_W  = 32;
	localparam int REC_N    = 12;
	localparam int GROUP_N  = 8;
	localparam int RAT_SHIFT = 8;
	localparam int SYNC_BLK  = 0;
	localparam int SYNC_BUS  = 1;
	localparam int SYNC_LINE = 2;

	// ****************************************
	// constants and reset values
	// ****************************************
	localparam logic [ANG_W-1:0]         ANG_FULL     = 16'h8CA0;
	localparam logic [ANG_W-1:0]         ANG_HALF     = 16'h4650;
	localparam logic [THR_W-1:0]         LOW_PICK_RST = 7'h05;
	localparam logic [THR_W-1:0]         HIGH_DET_RST = 7'h50;
	localparam logic [ANG_W-1:0]         ANG_LIM_RST  = 16'h01F4;
	localparam logic                     BUS_CHK_RST  = 1'h1;
	localparam logic                     LINE_CHK_RST = 1'h1;
	localparam logic [DLY_W-1:0]         OP_DLY_RST   = 19'h000C8;
	localparam logic signed [TIME_W-1:0] REM_MIN      = 20'hA81C0;
	localparam logic [RAT_W-1:0]         RAT_SAT      = 16'hFFFF;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [4:0] {
		MODE_ON = 5'h01, MODE_BLOCKED = 5'h02, MODE_TEST = 5'h04,
		MODE_TEST_BLOCKED = 5'h08, MODE_OFF = 5'h10
	} vsup_mode_t;

	typedef enum logic [4:0] {
		COND_NORMAL = 5'h01, COND_START = 5'h02, COND_LINE_FAIL = 5'h04,
		COND_BUS_FAIL = 5'h08, COND_BLOCKED = 5'h10
	} vsup_cond_t;

	typedef enum logic [4:0] {
		BUS_DEAD = 5'h01, BUS_LIVE_OK = 5'h02, BUS_LIVE_REV = 5'h04,
		BUS_LIVE_UNDEF = 5'h08, BUS_LIVE_PROBLEM = 5'h10
	} vsup_bus_t;

	typedef struct packed {
		logic [CH_N-1:0][MAG_W-1:0] mag;
		logic [CH_N-1:0][ANG_W-1:0] ang;
		logic [MAG_W-1:0]           pos_seq;
		logic [MAG_W-1:0]           neg_seq;
		logic [MAG_W-1:0]           zero_seq;
	} vsup_meas_t;

	typedef struct packed {
		logic [THR_W-1:0] low_pick;
		logic [THR_W-1:0] high_detect;
		logic [ANG_W-1:0] ang_limit;
		logic             bus_check;
		logic             line_check;
		logic [DLY_W-1:0] op_delay;
	} vsup_pick_set_t;

	localparam vsup_pick_set_t PICK_SET_RST = '{LOW_PICK_RST, HIGH_DET_RST,
		ANG_LIM_RST, BUS_CHK_RST, LINE_CHK_RST, OP_DLY_RST};

	typedef struct packed {
		logic [STAMP_W-1:0]        stamp;
		vsup_cond_t                cond;
		vsup_bus_t                 bus;
		logic signed [TIME_W-1:0]  remaining;
		logic [2:0]                group;
	} vsup_rec_t;

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [ANG_W-1:0] vsup_ang_diff(input logic [ANG_W-1:0] a,
		input logic [ANG_W-1:0] b);
		logic [ANG_W-1:0] d;
		d = (a >= b) ? a - b : b - a;
		if (d > ANG_HALF)
		begin
			d = ANG_FULL - d;
		end
		return d;
	endfunction

	function automatic logic [RAT_W-1:0] vsup_ratio(input logic [THR_W-1:0] set,
		input logic [MAG_W-1:0] mag);
		logic [RAT_W-1:0] num;
		logic [RAT_W-1:0] den;
		num = {1'h0, set, 8'h00};
		den = {4'h0, mag};
		return (mag == '0) ? RAT_SAT : num / den;
	endfunction

	function automatic logic vsup_below(input logic [MAG_W-1:0] mag,
		input logic [THR_W-1:0] thr);
		return mag < {5'h00, thr};
	endfunction

endpackage
`default_nettype wire

// ---- core/vsup_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsup_tick #(
	parameter int DIV = vsup_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// processing cycle enable
	output logic      tick
);
	import vsup_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} vsup_tick_state_t;

	vsup_tick_state_t q;
	vsup_tick_state_t d;

	always_comb
	begin
		d = q;
		d.tick = 1'h0;
		if (q.cnt >= 32'(DIV - 1))
		begin
			d.cnt = '0;
			d.tick = 1'h1;
		end
		else
		begin
			d.cnt = q.cnt + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;

endmodule
`default_nettype wire

// ---- core/vsup_angle_hist.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsup_angle_hist #(
	parameter int DEPTH = vsup_pkg::HIST_DEPTH
) (
	// clock and reset
	input  wire logic                                         core_clk,
	input  wire logic                                         rst_n,
	// sample strobe and angles
	input  wire logic                                         tick,
	input  wire logic [vsup_pkg::CH_N-1:0][vsup_pkg::ANG_W-1:0] ang,
	// shift against the sample DEPTH ticks back
	output logic [vsup_pkg::CH_N-1:0][vsup_pkg::ANG_W-1:0]      shift
);
	import vsup_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][CH_N-1:0][ANG_W-1:0] hist;
		logic [7:0]                            ptr;
		logic [CH_N-1:0][ANG_W-1:0]            shift;
	} vsup_hist_state_t;

	vsup_hist_state_t q;
	vsup_hist_state_t d;

	// the slot about to be overwritten holds the oldest sample
	always_comb
	begin
		d = q;
		if (tick)
		begin
			for (int c = 0; c < CH_N; c++)
			begin
				d.shift[c] = vsup_ang_diff(ang[c], q.hist[q.ptr][c]);
			end
			d.hist[q.ptr] = ang;
			d.ptr = (q.ptr == 8'(DEPTH - 1)) ? 8'h00 : q.ptr + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign shift = q.shift;

endmodule
`default_nettype wire

// ---- core/vsup_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsup_top #(
	parameter int TICK_DIV = vsup_pkg::TICK_CYC,
	parameter int GROUPS   = vsup_pkg::GROUP_N,
	parameter int RECS     = vsup_pkg::REC_N
) (
	// clock and reset
	input  wire logic                                        core_clk,
	input  wire logic                                        rst_n,
	// measurement front end
	input  wire vsup_pkg::vsup_meas_t                        meas,
	// pins
	input  wire logic                                        block_in,
	input  wire logic                                        bus_breaker_trip_input,
	input  wire logic                                        line_breaker_trip_input,
	// static settings
	input  wire vsup_pkg::vsup_mode_t                        logical_node_operating_mode,
	input  wire logic                                        force_enable,
	input  wire vsup_pkg::vsup_cond_t                        force_status,
	// setting groups
	input  wire vsup_pkg::vsup_pick_set_t                    pick_set [GROUPS],
	input  wire logic [2:0]                                  group_sel,
	// status
	output vsup_pkg::vsup_mode_t                             behaviour,
	output vsup_pkg::vsup_cond_t                             condition,
	output vsup_pkg::vsup_bus_t                              bus_state,
	output logic                                             pickup,
	output logic [vsup_pkg::DLY_W-1:0]                       expected_time,
	output logic signed [vsup_pkg::TIME_W-1:0]               remaining_time,
	output logic [vsup_pkg::PH_N-1:0][vsup_pkg::RAT_W-1:0]   ratio_low,
	output logic [vsup_pkg::PH_N-1:0][vsup_pkg::RAT_W-1:0]   ratio_high,
	// event pulses
	output logic                                             start_on,
	output logic                                             fail_on,
	output logic                                             block_on,
	// record readout
	input  wire logic [3:0]                                  rec_idx,
	output vsup_pkg::vsup_rec_t                              rec_out,
	output logic [3:0]                                       rec_count,
	output logic [3:0]                                       rec_wr_ptr
);
	import vsup_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_START = 4'h2, ST_FAIL = 4'h4, ST_BLOCKED = 4'h8
	} vsup_st_t;

	typedef struct packed {
		logic [2:0]                      sync1;
		logic [2:0]                      sync2;
		logic                            proc;
		vsup_mode_t                      mode;
		vsup_pick_set_t                  set;
		logic [2:0]                      group;
		vsup_st_t                        st;
		logic                            line_kind;
		logic                            pick;
		logic signed [TIME_W-1:0]        rem;
		vsup_cond_t                      cond;
		vsup_bus_t                       bus;
		logic [PH_N-1:0][RAT_W-1:0]      rat_lo;
		logic [PH_N-1:0][RAT_W-1:0]      rat_hi;
		logic                            start_ev;
		logic                            fail_ev;
		logic                            block_ev;
		logic [STAMP_W-1:0]              stamp;
		logic [RECS-1:0][$bits(vsup_rec_t)-1:0] rec;
		logic [3:0]                      wr_ptr;
		logic [3:0]                      count;
		vsup_rec_t                       rec_out;
	} vsup_top_state_t;

	vsup_top_state_t q;
	vsup_top_state_t d;

	logic                        tick;
	logic [CH_N-1:0][ANG_W-1:0]  shift;
	logic                        off;
	logic                        blk;
	logic                        low_any;
	logic [1:0]                  high_cnt;
	logic                        ang_blk;
	logic                        volt_pick;
	logic                        bus_fuse;
	logic                        line_fuse;
	logic                        line_pick;
	logic                        pick;
	vsup_pick_set_t              gset;

	// ****************************************
	// processing cycle and angle history
	// ****************************************
	vsup_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (tick)
	);

	vsup_angle_hist #(
		.DEPTH (HIST_DEPTH)
	) u_hist (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (tick),
		.ang      (meas.ang),
		.shift    (shift)
	);

	// ****************************************
	// pick-up conditions
	// ****************************************
	// the group is applied live; a group change reaches q.set two cycles later (q.group, then q.set)
	assign gset = pick_set[q.group];
	assign off = (q.mode == MODE_OFF);
	assign blk = q.sync2[SYNC_BLK] | (q.mode == MODE_BLOCKED) | (q.mode == MODE_TEST_BLOCKED);

	always_comb
	begin
		low_any = 1'h0;
		high_cnt = 2'h0;
		ang_blk = 1'h1;
		for (int p = 0; p < PH_N; p++)
		begin
			low_any = low_any | vsup_below(meas.mag[p], q.set.low_pick);
			if (!vsup_below(meas.mag[p], q.set.high_detect) &&
				meas.mag[p] != {5'h00, q.set.high_detect})
			begin
				high_cnt = (high_cnt == 2'h3) ? high_cnt : high_cnt + 2'h1;
			end
			// no phase jumped: treat as a steady supply and hold the voltage pick-ups off (fuse inputs still pick up)
			ang_blk = ang_blk & (shift[p] < q.set.ang_limit);
		end
	end

	assign volt_pick = (low_any | (high_cnt >= 2'h2)) & ~ang_blk;
	assign bus_fuse  = q.set.bus_check & q.sync2[SYNC_BUS];
	assign line_fuse = q.set.line_check & q.sync2[SYNC_LINE];
	assign line_pick = line_fuse | (vsup_below(meas.mag[CH_N-1], q.set.low_pick) & ~ang_blk);
	assign pick = ~off & (volt_pick | bus_fuse | line_pick);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		d = q;
		d.sync1 = {line_breaker_trip_input, bus_breaker_trip_input, block_in};
		d.sync2 = q.sync1;
		d.proc = tick;
		d.mode = logical_node_operating_mode;
		d.group = group_sel;
		d.set = gset;
		d.start_ev = 1'h0;
		d.fail_ev = 1'h0;
		d.block_ev = 1'h0;
		if (q.proc)
		begin
			d.stamp = q.stamp + 32'h1;
			d.pick = pick;
			for (int p = 0; p < PH_N; p++)
			begin
				d.rat_lo[p] = vsup_ratio(q.set.low_pick, meas.mag[p]);
				d.rat_hi[p] = vsup_ratio(q.set.high_detect, meas.mag[p]);
			end
			case (q.st)
				ST_IDLE:
				begin
					d.rem = signed'({1'h0, q.set.op_delay});
					if (pick && blk)
					begin
						d.st = ST_BLOCKED;
						d.block_ev = 1'h1;
					end
					else if (pick)
					begin
						d.st = ST_START;
						d.start_ev = 1'h1;
						d.line_kind = line_pick & ~(volt_pick | bus_fuse);
					end
				end
				ST_START, ST_FAIL:
				begin
					if (!pick)
					begin
						d.st = ST_IDLE;
					end
					else if (blk)
					begin
						d.st = ST_BLOCKED;
						d.block_ev = 1'h1;
					end
					else if (q.st == ST_START && q.rem == '0)
					begin
						d.st = ST_FAIL;
						d.fail_ev = 1'h1;
					end
					// past expiry the count runs negative to show overrun
					if (pick && !blk && q.rem != REM_MIN)
					begin
						d.rem = q.rem - 20'sh00001;
					end
					if (!pick || blk)
					begin
						d.rem = signed'({1'h0, q.set.op_delay});
					end
				end
				ST_BLOCKED:
				begin
					d.rem = signed'({1'h0, q.set.op_delay});
					if (!pick)
					begin
						d.st = ST_IDLE;
					end
					else if (!blk)
					begin
						d.st = ST_START;
						d.start_ev = 1'h1;
						d.line_kind = line_pick & ~(volt_pick | bus_fuse);
					end
				end
				default:
				begin
					d.st = ST_IDLE;
				end
			endcase
			if (off)
			begin
				d.st = ST_IDLE;
				d.start_ev = 1'h0;
				d.fail_ev = 1'h0;
				d.block_ev = 1'h0;
			end
			if (off || meas.mag[PH_N-1:0] == '0)
				d.bus = BUS_DEAD;
			else if (pick)
				d.bus = BUS_LIVE_PROBLEM;
			else if (vsup_below(meas.pos_seq, q.set.low_pick))
				d.bus = BUS_LIVE_UNDEF;
			else if (meas.neg_seq > meas.pos_seq)
				d.bus = BUS_LIVE_REV;
			else
				d.bus = BUS_LIVE_OK;
		end
		case (d.st)
			ST_START:   d.cond = COND_START;
			ST_FAIL:    d.cond = d.line_kind ? COND_LINE_FAIL : COND_BUS_FAIL;
			ST_BLOCKED: d.cond = COND_BLOCKED;
			default:    d.cond = COND_NORMAL;
		endcase
		if (force_enable)
		begin
			d.cond = force_status;
		end
		if (d.start_ev || d.fail_ev || d.block_ev)
		begin
			d.rec[q.wr_ptr] = {q.stamp, d.cond, d.bus, d.rem, q.group};
			d.wr_ptr = (q.wr_ptr == 4'(RECS - 1)) ? 4'h0 : q.wr_ptr + 4'h1;
			d.count = (q.count == 4'(RECS)) ? q.count : q.count + 4'h1;
		end
		d.rec_out = (rec_idx < 4'(RECS)) ? vsup_rec_t'(q.rec[rec_idx]) : '0;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.mode <= MODE_ON;
			q.set <= PICK_SET_RST;
			q.st <= ST_IDLE;
			q.cond <= COND_NORMAL;
			q.bus <= BUS_DEAD;
		end
		else
		begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign behaviour      = q.mode;
	assign condition      = q.cond;
	assign bus_state      = q.bus;
	assign pickup         = q.pick;
	assign expected_time  = q.set.op_delay;
	assign remaining_time = q.rem;
	assign ratio_low      = q.rat_lo;
	assign ratio_high     = q.rat_hi;
	assign start_on       = q.start_ev;
	assign fail_on        = q.fail_ev;
	assign block_on       = q.block_ev;
	assign rec_out        = q.rec_out;
	assign rec_count      = q.count;
	assign rec_wr_ptr     = q.wr_ptr;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_idle_pick;
		q.proc && !off && q.st == ST_IDLE && pick;
	endsequence

	sequence s_start_pick;
		q.proc && !off && q.st == ST_START && pick;
	endsequence

	AST_START_ON_PICK: assert property (s_idle_pick and !blk |=> q.st == ST_START && start_on)
		else $error("pick-up without block did not start");

	AST_BLOCK_ON_PICK: assert property (s_idle_pick and blk |=> q.st == ST_BLOCKED && !start_on)
		else $error("pick-up under block did not give blocked");

	AST_START_RESET: assert property (s_start_pick and blk |=> q.st == ST_BLOCKED && q.rem == signed'({1'h0, $past(q.set.op_delay)}))
		else $error("block during start did not reset it");

	AST_DT_EXPIRY: assert property (s_start_pick and !blk and q.rem == '0 |=> fail_on ##1 !fail_on)
		else $error("definite-time expiry did not fail once");

	AST_FAIL_KIND: assert property (q.st == ST_FAIL && !force_enable |-> condition == COND_LINE_FAIL || condition == COND_BUS_FAIL)
		else $error("fail state without fail condition");

	AST_COUNT_DOWN: assert property (s_start_pick and !blk and q.rem != '0 |=> q.rem == $past(q.rem) - 20'sh00001)
		else $error("remaining time did not step down");

	AST_PROBLEM: assert property (q.proc && pick && meas.mag[PH_N-1:0] != '0 |=> bus_state == BUS_LIVE_PROBLEM)
		else $error("pick-up not reported as bus problem");

	AST_LOW_PICK: assert property (q.proc && !off && low_any && !ang_blk |=> pickup)
		else $error("low phase did not pick up");

	AST_ANG_BLOCK: assert property (q.proc && ang_blk && !bus_fuse && !line_fuse |=> !pickup)
		else $error("steady angles did not hold pick-up off");

	AST_MODE_READ: assert property (##1 behaviour == $past(logical_node_operating_mode))
		else $error("behaviour does not follow mode");

	AST_FORCE: assert property (force_enable |=> condition == $past(force_status))
		else $error("forced status not shown");

	AST_REC_COUNT: assert property (start_on && rec_count != 4'(RECS) |-> rec_count == $past(rec_count) + 4'h1)
		else $error("record not stored on event");

endmodule
`default_nettype wire

// ---- tb/vsup_front_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsup_front_model #(
	parameter int DIV = 20
) (
	// clock and reset
	input  wire logic                                          core_clk,
	input  wire logic                                          rst_n,
	// wanted magnitudes and angle motion
	input  wire logic [vsup_pkg::CH_N-1:0][vsup_pkg::MAG_W-1:0] mag_in,
	input  wire logic                                          jump,
	input  wire logic                                          rev,
	// measurements
	output vsup_pkg::vsup_meas_t                               meas
);
	import vsup_pkg::*;

	int cnt;

	// ****************************************
	// refresh
	// ****************************************
	// refresh mid-interval so values never move at the sampling cycle
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			meas <= '0;
		end
		else
		begin
			cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
			if (cnt == DIV / 2)
			begin
				meas.mag <= mag_in;
				meas.pos_seq <= mag_in[0];
				// full-scale negative sequence makes the bus read as reversed
				meas.neg_seq <= rev ? 12'hFFF : 12'h000;
				meas.zero_seq <= 12'h000;
				for (int i = 0; i < CH_N; i++)
					meas.ang[i] <= (meas.ang[i] + (jump ? 16'h03E8 : 16'h0000)) % ANG_FULL;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/vsup_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
	n_compared++; \
	if ((got) !== (ex)) \
	begin \
		$display("MISMATCH %s expected %h seen %h", nm, ex, got); \
		err_count++; \
	end
module vsup_top_tb;
	import vsup_pkg::*;

	localparam int TD  = 20;
	localparam int DLY = 3;

	logic                       core_clk = 0;
	logic                       rst_n = 0;
	logic                       block_in = 0;
	logic                       bus_breaker_trip_input = 0;
	logic                       line_breaker_trip_input = 0;
	logic                       force_enable = 0;
	logic                       jump = 0;
	logic                       rev = 0;
	logic [PH_N-1:0][RAT_W-1:0] ratio_high;
	vsup_rec_t                  rec_out;
	logic [3:0]                 rec_wr_ptr;
	logic [2:0]                 group_sel = 3'h0;
	logic [CH_N-1:0][MAG_W-1:0] mag_in;
	vsup_meas_t                 meas;
	vsup_mode_t                 mode = MODE_ON;
	vsup_cond_t                 force_status = COND_NORMAL;
	vsup_pick_set_t             pick_set [GROUP_N];
	vsup_mode_t                 behaviour;
	vsup_cond_t                 condition;
	vsup_bus_t                  bus_state;
	logic                       pickup;
	logic                       start_on;
	logic                       fail_on;
	logic                       block_on;
	logic [DLY_W-1:0]           expected_time;
	logic signed [TIME_W-1:0]   remaining_time;
	logic [PH_N-1:0][RAT_W-1:0] ratio_low;
	logic [3:0]                 rec_count;
	logic [9:0]                 exp_q [$];
	logic [9:0]                 exp_v;
	int                         err_count = 0;
	int                         n_compared = 0;
	int                         cyc = 0;
	int                         t_start = 0;
	int                         n_ev = 0;

	always #12.5 core_clk = ~core_clk;

	vsup_front_model #(.DIV(TD)) vsup_front_model_inst (.core_clk(core_clk), .rst_n(rst_n),
		.mag_in(mag_in), .jump(jump), .rev(rev), .meas(meas));

	vsup_top #(.TICK_DIV(TD)) vsup_top_inst (.core_clk(core_clk), .rst_n(rst_n), .meas(meas),
		.block_in(block_in), .bus_breaker_trip_input(bus_breaker_trip_input),
		.line_breaker_trip_input(line_breaker_trip_input),
		.logical_node_operating_mode(mode), .force_enable(force_enable),
		.force_status(force_status), .pick_set(pick_set), .group_sel(group_sel),
		.behaviour(behaviour), .condition(condition), .bus_state(bus_state), .pickup(pickup),
		.expected_time(expected_time), .remaining_time(remaining_time),
		.ratio_low(ratio_low), .ratio_high(ratio_high), .start_on(start_on), .fail_on(fail_on),
		.block_on(block_on), .rec_idx(4'h0), .rec_out(rec_out), .rec_count(rec_count),
		.rec_wr_ptr(rec_wr_ptr));

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// monitor
	// ****************************************
	always @(posedge core_clk)
	begin
		#1;
		cyc++;
		if (start_on === 1'b1)
			t_start = cyc;
		if (fail_on === 1'b1)
		begin
			`CHK("delay", (DLY + 1) * TD, cyc - t_start)
		end
		if ((start_on | fail_on | block_on) === 1'b1)
		begin
			n_ev++;
			exp_v = exp_q.pop_front();
			`CHK("cond_bus", exp_v, {condition, bus_state})
		end
		// ceiling well above the roughly 1700 cycles the sequence needs
		if (cyc > 6000)
		begin
			err_count++;
			finish_test();
		end
	end

	// ****************************************
	// driver
	// ****************************************
	task automatic clk(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	task automatic done(input string nm);
		`CHK("queue", 0, exp_q.size())
		$display("test %s done", nm);
	endtask

	task automatic norm();
		for (int i = 0; i < PH_N; i++)
			mag_in[i] = 12'(10 + $urandom % 100);
		mag_in[3] = 12'h064;
	endtask

	task automatic fuse(input logic on_bus, input logic chk, input vsup_cond_t fc);
		foreach (pick_set[g])
		begin
			pick_set[g].bus_check = chk;
			pick_set[g].line_check = chk;
		end
		if (chk)
		begin
			exp_q.push_back({COND_START, BUS_LIVE_PROBLEM});
			exp_q.push_back({fc, BUS_LIVE_PROBLEM});
		end
		bus_breaker_trip_input = on_bus;
		line_breaker_trip_input = !on_bus;
		clk((DLY + 4) * TD);
		bus_breaker_trip_input = 0;
		line_breaker_trip_input = 0;
		clk(2 * TD);
		`CHK("cond", COND_NORMAL, condition)
		done("fuse");
	endtask

	initial
	begin
		void'($urandom(32'hEB66277C));
		foreach (pick_set[g])
			pick_set[g] = '{7'h05, 7'h6E, 16'h01F4, 1'h1, 1'h1, 19'h00003};
		pick_set[1].op_delay = 19'h00005;
		norm();
		clk(4);
		`CHK("exp_rst", OP_DLY_RST, expected_time)
		rst_n = 1;
		clk(12 * TD);
		`CHK("exp_time", 19'h00003, expected_time)
		`CHK("remain", 20'h00003, remaining_time)
		`CHK("ratio", 16'(1280 / mag_in[0]), ratio_low[0])
		`CHK("ratio_hi", 16'(28160 / mag_in[0]), ratio_high[0])
		`CHK("pickup", 1'b0, pickup)
		`CHK("bus_ok", BUS_LIVE_OK, bus_state)
		rev = 1;
		clk(2 * TD);
		`CHK("bus_rev", BUS_LIVE_REV, bus_state)
		rev = 0;
		clk(2 * TD);
		done("reset");
		fuse(1'b1, 1'b1, COND_BUS_FAIL);
		fuse(1'b0, 1'b1, COND_LINE_FAIL);
		fuse(1'b1, 1'b0, COND_NORMAL);
		fuse(1'b0, 1'b0, COND_NORMAL);
		mag_in[0] = 12'h003;
		clk(4 * TD);
		`CHK("steady", 1'b0, pickup)
		`CHK("bus_undef", BUS_LIVE_UNDEF, bus_state)
		exp_q.push_back({COND_START, BUS_LIVE_PROBLEM});
		jump = 1;
		clk(3 * TD);
		exp_q.push_back({COND_BLOCKED, BUS_LIVE_PROBLEM});
		block_in = 1;
		clk(2 * TD);
		norm();
		jump = 0;
		clk(10 * TD);
		block_in = 0;
		done("block");
		exp_q.push_back({COND_START, BUS_LIVE_PROBLEM});
		exp_q.push_back({COND_BUS_FAIL, BUS_LIVE_PROBLEM});
		mag_in[0] = 12'h070;
		mag_in[2] = 12'h070;
		jump = 1;
		clk((DLY + 4) * TD);
		norm();
		jump = 0;
		clk(2 * TD);
		done("high");
		`CHK("records", 4'(n_ev < REC_N ? n_ev : REC_N), rec_count)
		`CHK("wr_ptr", 4'(n_ev % REC_N), rec_wr_ptr)
		`CHK("rec0", {COND_START, BUS_LIVE_PROBLEM, 20'h00003}, {rec_out.cond, rec_out.bus, rec_out.remaining})
		group_sel = 3'h1;
		clk(3);
		`CHK("grp_time", 19'h00005, expected_time)
		`CHK("grp_mode", MODE_ON, behaviour)
		done("group");
		force_enable = 1;
		for (int i = 0; i < 5; i++)
		begin
			force_status = vsup_cond_t'(5'h01 << i);
			clk(2);
			`CHK("forced", force_status, condition)
		end
		force_enable = 0;
		done("force");
		for (int i = 0; i < 5; i++)
		begin
			mode = vsup_mode_t'(5'h01 << i);
			clk(2);
			`CHK("mode", mode, behaviour)
		end
		mag_in[1] = 12'h003;
		jump = 1;
		clk(3 * TD);
		`CHK("off", 1'b0, pickup)
		`CHK("bus_dead", BUS_DEAD, bus_state)
		done("mode");
		finish_test();
	end
endmodule
`default_nettype wire
